/* File: hw/i2c_port_pkg.sv */
package i2c_port_pkg;

  // ****************************************
  // framing
  // ****************************************
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_END = 4'h9;

  // ****************************************
  // address
  // ****************************************
  localparam logic [2:0] ADDR_FIXED = 3'h2;
  localparam int ADDR_W = 7;
  localparam int SEL_W = 4;

  typedef logic [1:0] pin_code_t;
  localparam pin_code_t PIN_GND = 2'h0;
  localparam pin_code_t PIN_FLOAT = 2'h1;
  localparam pin_code_t PIN_HIGH = 2'h2;

  localparam logic [1:0] LOW_HIGH = 2'h0;
  localparam logic [1:0] LOW_FLOAT = 2'h2;
  localparam logic [1:0] LOW_GND = 2'h3;

  // pad code to two address bits; an illegal code reads as floating
  function automatic logic [1:0] sel_bits(input pin_code_t code);
    logic [1:0] bits;
    bits = LOW_FLOAT;
    unique case (code)
      PIN_HIGH: bits = LOW_HIGH;
      PIN_GND: bits = LOW_GND;
      default: bits = LOW_FLOAT;
    endcase
    return bits;
  endfunction : sel_bits

  // ****************************************
  // write path and transaction states
  // ****************************************
  typedef logic [1:0] role_t;
  localparam role_t ROLE_PTR = 2'h0;
  localparam role_t ROLE_MSB = 2'h1;
  localparam role_t ROLE_LSB = 2'h2;

  typedef struct packed {
    logic [7:0] ptr;
    logic [15:0] data;
  } wr_word_s;
  localparam int WORD_W = 24;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ = 5'h08,
    ST_SKIP = 5'h10
  } state_e;

endpackage : i2c_port_pkg

/* File: hw/i2c_register_target_port.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RULE_01] lines idle high, open-drain drive only
// [RULE_02] data falling while clock high starts
// [RULE_03] controller alone drives the clock
// [RULE_04] nine clocks per byte including acknowledge
// [RULE_05] data changes only while clock low
// [RULE_06] receiver acknowledges low; missing ack abandons
// [RULE_07] address byte with direction bit selects target
// [RULE_08] a transaction writes or reads, never both
// [RULE_09] repeated start begins a fresh transaction
// [RULE_10] data rising while clock high stops
// [RULE_11] address 010 plus two select pins
// [RULE_12] pointer, msb, lsb bytes per write
// [RULE_13] target acknowledges address, pointer, data bytes; the lsb byte is nacked here while the write buffer is full
// [RULE_14] further pointer plus pair per write
// [RULE_15] repeated reads from the same pointer
// [RULE_16] pointer persists across transactions
// [RULE_17] read sends high then low repeatedly
// [RULE_18] controller nack makes target release data
// [RULE_19] pointer-only write just loads the pointer
// [RULE_20] bits travel most significant first
module i2c_register_target_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire i2c_port_pkg::pin_code_t addr_select_pin_a,
  input wire i2c_port_pkg::pin_code_t addr_select_pin_b,
  output logic [i2c_port_pkg::ADDR_W-1:0] target_addr,
  output logic [7:0] reg_ptr,
  input wire logic [15:0] rd_data,
  output logic rd_strobe,
  output logic wr_valid,
  input wire logic wr_ready,
  output var i2c_port_pkg::wr_word_s wr_word
);
  import i2c_port_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // pin sampling
  // ****************************************
  logic [1:0] bus_q;
  logic [1:0] bus_rise;
  logic [1:0] bus_fall;
  logic [SEL_W-1:0] sel_q;
  logic scl;
  logic sda;

  // [RULE_03] clock sampled only
  pin_sync #(.W(2)) u_bus_sync (
    .clock(clock),
    .rst_n(rst_sync_q),
    .d({scl_i, sda_i}),
    .q(bus_q),
    .rise(bus_rise),
    .fall(bus_fall)
  );

  pin_sync #(.W(SEL_W)) u_sel_sync (
    .clock(clock),
    .rst_n(rst_sync_q),
    .d({addr_select_pin_b, addr_select_pin_a}),
    .q(sel_q),
    .rise(),
    .fall()
  );

  assign scl = bus_q[1];
  assign sda = bus_q[0];

  // ****************************************
  // bus conditions and bit timing
  // ****************************************
  state_e state_q;
  state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic start_w;
  logic stop_w;
  logic scl_rise;
  logic scl_fall;
  logic ack_slot;
  logic frame_end;
  logic ack_rise;

  assign scl_rise = bus_rise[1];
  assign scl_fall = bus_fall[1];
  // [RULE_02] start detect
  // [RULE_09] repeated start too
  assign start_w = bus_fall[0] & scl;
  // [RULE_10] stop detect
  assign stop_w = bus_rise[0] & scl;
  // [RULE_04] ninth clock is acknowledge
  assign ack_slot = scl_fall & (cnt_q == CNT_ACK);
  assign ack_rise = scl_rise & (cnt_q == CNT_ACK);
  assign frame_end = scl_fall & (cnt_q == CNT_END);
  assign cnt_d = start_w ? CNT_ZERO :
                 frame_end ? CNT_ZERO :
                 scl_rise ? cnt_q + CNT_ONE : cnt_q;

  // ****************************************
  // address match
  // ****************************************
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [7:0] rx_q;
  logic match_w;
  logic rw_q;

  // [RULE_11] fixed high bits plus select pins
  assign addr_d = {ADDR_FIXED, sel_bits(sel_q[3:2]), sel_bits(sel_q[1:0])};
  // [RULE_07] compare seven address bits
  assign match_w = (rx_q[7:1] == addr_q);

  // ****************************************
  // write path
  // ****************************************
  role_t role_q;
  logic [7:0] ptr_q;
  logic [7:0] msb_q;
  logic nack_q;
  logic fifo_in_ready;
  logic push_w;
  logic wr_ack_w;
  logic st_addr;
  logic st_write;
  logic st_read;
  wr_word_s push_word;

  assign st_addr = (state_q == ST_ADDR);
  assign st_write = (state_q == ST_WRITE);
  assign st_read = (state_q == ST_READ);
  // [RULE_13] ack every write byte buffer can take
  assign wr_ack_w = (role_q != ROLE_LSB) | fifo_in_ready;
  // [RULE_12] lsb completes a register word
  assign push_w = ack_slot & st_write & (role_q == ROLE_LSB) & fifo_in_ready;
  assign push_word.ptr = ptr_q;
  assign push_word.data = {msb_q, rx_q};

  word_pair_fifo #(.WIDTH(WORD_W)) u_fifo (
    .clock(clock),
    .rst_n(rst_sync_q),
    .in_valid(push_w),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [15:0] word_q;
  logic lo_next_q;
  logic master_ack_q;
  logic load_hi_w;
  logic load_lo_w;
  logic shift_w;
  logic [7:0] tx_byte_w;

  // [RULE_17] high byte then low, again and again
  assign load_hi_w = (st_addr & frame_end & rw_q) |
                     (st_read & frame_end & master_ack_q & ~lo_next_q);
  assign load_lo_w = st_read & frame_end & master_ack_q & lo_next_q;
  // [RULE_05] next bit placed on clock fall
  assign shift_w = st_read & scl_fall & (cnt_q != CNT_ZERO) & (cnt_q < CNT_ACK);
  assign tx_byte_w = load_hi_w ? rd_data[15:8] : word_q[7:0];
  // [RULE_20] msb out first
  assign tx_d = (load_hi_w | load_lo_w) ? tx_byte_w :
                shift_w ? {tx_q[6:0], 1'b0} : tx_q;

  // ****************************************
  // transaction state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_ADDR:
      begin
        if (ack_slot & ~match_w)
          state_d = ST_SKIP;
        // [RULE_08] direction fixed for the transaction
        else if (frame_end)
          state_d = rw_q ? ST_READ : ST_WRITE;
      end
      ST_WRITE:
      begin
        // [RULE_06] own nack abandons the write
        if (frame_end & nack_q)
          state_d = ST_SKIP;
      end
      ST_READ:
      begin
        // [RULE_18] controller nack ends sending
        if (frame_end & ~master_ack_q)
          state_d = ST_SKIP;
      end
      ST_SKIP: state_d = ST_SKIP;
    endcase
    if (start_w)
      state_d = ST_ADDR;
    else if (stop_w)
      state_d = ST_IDLE;
  end

  always_ff @(posedge clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      rx_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      // [RULE_20] shift in msb first
      if (scl_rise & (cnt_q < CNT_ACK))
        rx_q <= {rx_q[6:0], sda};
    end
  end

  // pins are read while the bus is idle so a strap change waits for a gap
  always_ff @(posedge clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      addr_q <= '0;
      rw_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_IDLE)
        addr_q <= addr_d;
      if (st_addr & ack_slot)
        rw_q <= rx_q[0];
    end
  end

  // ****************************************
  // pointer and data capture
  // ****************************************
  always_ff @(posedge clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      role_q <= ROLE_PTR;
      ptr_q <= '0;
      msb_q <= '0;
      nack_q <= 1'b0;
    end
    else if (start_w)
    begin
      role_q <= ROLE_PTR;
      nack_q <= 1'b0;
    end
    else if (st_write & ack_slot)
    begin
      nack_q <= ~wr_ack_w;
      unique case (role_q)
        // [RULE_19] pointer byte alone loads the pointer
        // [RULE_16] pointer kept across transactions
        ROLE_PTR:
        begin
          ptr_q <= rx_q;
          role_q <= ROLE_MSB;
        end
        ROLE_MSB:
        begin
          msb_q <= rx_q;
          role_q <= ROLE_LSB;
        end
        // [RULE_14] next byte is a new pointer
        ROLE_LSB: role_q <= ROLE_PTR;
        default: role_q <= ROLE_PTR;
      endcase
    end
  end

  // ****************************************
  // read sequencing
  // ****************************************
  always_ff @(posedge clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      tx_q <= '0;
      word_q <= '0;
      lo_next_q <= 1'b0;
      master_ack_q <= 1'b0;
      rd_strobe <= 1'b0;
    end
    else
    begin
      tx_q <= tx_d;
      // [RULE_15] fresh word from the same pointer
      rd_strobe <= load_hi_w;
      if (load_hi_w)
        word_q <= rd_data;
      if (load_hi_w)
        lo_next_q <= 1'b1;
      else if (load_lo_w | start_w)
        lo_next_q <= 1'b0;
      // [RULE_06] controller ack sampled in ninth clock
      if (st_read & ack_rise)
        master_ack_q <= ~sda;
    end
  end

  // ****************************************
  // data line drive
  // ****************************************
  logic oe_q;
  logic oe_d;

  // [RULE_01] only ever pull low or release
  always_comb
  begin
    oe_d = oe_q;
    if (start_w | stop_w)
      oe_d = 1'b0;
    // [RULE_13] address acknowledged on match
    else if (st_addr & ack_slot)
      oe_d = match_w;
    else if (st_write & ack_slot)
      oe_d = wr_ack_w;
    else if (load_hi_w | load_lo_w)
      oe_d = ~tx_byte_w[7];
    else if (shift_w)
      oe_d = ~tx_q[6];
    // [RULE_18] release for controller ack or after nack
    else if (st_read & ack_slot)
      oe_d = 1'b0;
    else if (frame_end)
      oe_d = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      oe_q <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      oe_q <= oe_d;
      sda_o <= 1'b0;
    end
  end

  assign sda_oe = oe_q;
  assign target_addr = addr_q;
  assign reg_ptr = ptr_q;
endmodule : i2c_register_target_port
`default_nettype wire

/* File: hw/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // ****************************************
  // two-stage synchroniser and edge finder
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          prev_q[i] <= 1'b1;
        end
        else
        begin
          meta_q[i] <= d[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
    end
  endgenerate

  assign q = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule : pin_sync
`default_nettype wire

/* File: hw/word_pair_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module word_pair_fifo #(
  parameter int WIDTH = 24
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic head_v_q;
  logic tail_v_q;
  logic push;
  logic pop;

  // ****************************************
  // two entries, head always presented
  // ****************************************
  assign in_ready = ~tail_v_q;
  assign push = in_valid & ~tail_v_q;
  assign pop = head_v_q & out_ready;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end
    else
    begin
      head_v_q <= pop ? (tail_v_q | push) : (head_v_q | push);
      tail_v_q <= pop ? 1'b0 : (tail_v_q | (head_v_q & push));
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_q <= '0;
      tail_q <= '0;
    end
    else
    begin
      if (pop)
        head_q <= tail_v_q ? tail_q : in_data;
      else if (!head_v_q)
        head_q <= in_data;
      if (head_v_q & !pop & push)
        tail_q <= in_data;
    end
  end

  assign out_valid = head_v_q;
  assign out_data = head_q;
endmodule : word_pair_fifo
`default_nettype wire

/* File: testbench/i2c_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_ctl_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  // ****************************************
  // bus controller
  // ****************************************
  // idle released
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic wq(input int n);
    repeat (n) @(posedge clock);
  endtask : wq

  task automatic start;
    wq(5);
    pull <= 1'b0;
    wq(5);
    scl <= 1'b1;
    wq(5);
    pull <= 1'b1;
    wq(5);
    scl <= 1'b0;
  endtask : start

  task automatic bit_io(input logic b, output logic s);
    wq(5);
    pull <= ~b;
    wq(5);
    scl <= 1'b1;
    wq(5);
    s = sda;
    wq(5);
    scl <= 1'b0;
  endtask : bit_io

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask : recv_byte

  task automatic stop;
    wq(5);
    pull <= 1'b1;
    wq(5);
    scl <= 1'b1;
    wq(5);
    pull <= 1'b0;
    wq(10);
  endtask : stop
endmodule : i2c_ctl_model
`default_nettype wire

/* File: testbench/i2c_port_props.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_port_props
  import i2c_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire i2c_port_pkg::pin_code_t addr_select_pin_a,
  input wire i2c_port_pkg::pin_code_t addr_select_pin_b,
  input wire logic [i2c_port_pkg::ADDR_W-1:0] target_addr,
  input wire logic [7:0] reg_ptr,
  input wire logic [15:0] rd_data,
  input wire logic rd_strobe,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire i2c_port_pkg::wr_word_s wr_word
);
  // ****************************************
  // link and buffer checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  odrain_low_a: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  ack_rise_a: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data drive begins with clock high");
  ack_fall_a: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("data release with clock high");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data drive too short");
  ptr_update_a: assert property ($changed(reg_ptr) |-> !scl_i)
    else $error("pointer moved outside ack fall");
  strobe_once_a: assert property (rd_strobe |=> !rd_strobe)
    else $error("read strobe longer than one cycle");
  strobe_low_a: assert property (rd_strobe |-> !scl_i)
    else $error("read strobe with clock high");
  word_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("write word lost while stalled");
  push_low_a: assert property ($rose(wr_valid) |-> !scl_i)
    else $error("word pushed outside ack fall");
  addr_top_a: assert property ($changed(target_addr) |-> target_addr[6:4] == ADDR_FIXED && scl_i && sda_i)
    else $error("address changed badly");
endmodule : i2c_port_props

bind i2c_register_target_port i2c_port_props u_props (.clock(clock), .rst_n(rst_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .addr_select_pin_a(addr_select_pin_a), .addr_select_pin_b(addr_select_pin_b),
  .target_addr(target_addr), .reg_ptr(reg_ptr), .rd_data(rd_data), .rd_strobe(rd_strobe),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
  import i2c_port_pkg::*;
  localparam logic [6:0] ADDR = 7'h2e;
  logic clock, rst_n, wr_ready, m_scl, m_pull, sda_oe, sda_o, rd_strobe, wr_valid;
  pin_code_t pin_a, pin_b;
  logic [15:0] rd_data;
  logic [6:0] target_addr;
  logic [7:0] reg_ptr;
  wr_word_s wr_word;
  int failures = 0;
  int n_checks = 0;
  int n_strobe = 0;
  wire sda = ~(sda_oe | m_pull);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  i2c_register_target_port uut (.clock(clock), .rst_n(rst_n), .scl_i(m_scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin_a(pin_a), .addr_select_pin_b(pin_b),
    .target_addr(target_addr), .reg_ptr(reg_ptr), .rd_data(rd_data), .rd_strobe(rd_strobe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));
  i2c_ctl_model ctl (.clock(clock), .sda(sda), .scl(m_scl), .pull(m_pull));

  // ****************************************
  // helpers
  // ****************************************
  always @(posedge clock) rd_data <= {~reg_ptr, reg_ptr};
  always @(posedge clock) if (rd_strobe === 1'b1) n_strobe++;

  function automatic logic [1:0] low_of(input pin_code_t c);
    return (c == PIN_HIGH) ? 2'h0 : (c == PIN_GND) ? 2'h3 : 2'h2;
  endfunction : low_of

  task automatic wr_b(input logic [7:0] d, input logic exp);
    logic ack;
    ctl.send_byte(d, ack);
    `CHK(ack, exp)
  endtask : wr_b

  task automatic rd_b(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    ctl.recv_byte(ack, d);
    `CHK(d, exp)
  endtask : rd_b

  task automatic take_one;
    @(posedge clock) wr_ready <= 1'b1;
    @(posedge clock) wr_ready <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : take_one

  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_addr;
    pin_code_t codes [3] = '{PIN_HIGH, PIN_FLOAT, PIN_GND};
    for (int b = 0; b < 3; b++)
      for (int a = 0; a < 3; a++)
      begin
        pin_a <= codes[a];
        pin_b <= codes[b];
        repeat (10) @(posedge clock);
        `CHK(target_addr, {3'h2, low_of(codes[b]), low_of(codes[a])})
      end
    pin_a <= PIN_FLOAT;
    repeat (10) @(posedge clock);
    ctl.start;
    wr_b({7'h20, 1'b0}, 1'b0);
    ctl.stop;
  endtask : t_addr

  task automatic t_write;
    ctl.start;
    wr_b({ADDR, 1'b0}, 1'b1);
    wr_b(8'h11, 1'b1);
    wr_b(8'h12, 1'b1);
    wr_b(8'h34, 1'b1);
    wr_b(8'h22, 1'b1);
    wr_b(8'h56, 1'b1);
    wr_b(8'h78, 1'b1);
    wr_b(8'h33, 1'b1);
    wr_b(8'h9a, 1'b1);
    wr_b(8'hbc, 1'b0);
    ctl.stop;
    `CHK(reg_ptr, 8'h33)
    `CHK(wr_word, {8'h11, 16'h1234})
    take_one;
    `CHK(wr_word, {8'h22, 16'h5678})
    take_one;
    `CHK(wr_valid, 1'b0)
  endtask : t_write

  task automatic t_read;
    ctl.start;
    wr_b({ADDR, 1'b0}, 1'b1);
    wr_b(8'h40, 1'b1);
    ctl.stop;
    `CHK(reg_ptr, 8'h40)
    ctl.start;
    wr_b({ADDR, 1'b1}, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      rd_b(1'b1, 8'hbf);
      rd_b(k == 0, 8'h40);
    end
    repeat (6) @(posedge clock);
    `CHK(sda_oe, 1'b0)
    `CHK(sda_o, 1'b0)
    `CHK(n_strobe, 2)
    ctl.stop;
    ctl.start;
    wr_b({ADDR, 1'b0}, 1'b1);
    wr_b(8'h5a, 1'b1);
    ctl.start;
    wr_b({ADDR, 1'b1}, 1'b1);
    rd_b(1'b1, 8'ha5);
    rd_b(1'b0, 8'h5a);
    ctl.stop;
    ctl.start;
    wr_b({ADDR, 1'b1}, 1'b1);
    rd_b(1'b1, 8'ha5);
    rd_b(1'b0, 8'h5a);
    ctl.stop;
    `CHK(n_strobe, 4)
  endtask : t_read

  initial
  begin
    rst_n = 1'b0;
    wr_ready = 1'b0;
    pin_a = PIN_HIGH;
    pin_b = PIN_HIGH;
    rd_data = 16'h0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (20) @(posedge clock);
    t_addr;
    t_write;
    t_read;
    report_and_stop;
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    failures++;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
